/* File: logic/main_storage_word_port.sv */
// main_storage_word_port: word-wide storage cycles with byte selects, parity and cabinet decode
// assumes the requester holds its request fields steady on the accepting edge
`timescale 1ns/100ps
module main_storage_word_port (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // request
  input wire logic REQ_I,
  input wire logic WE_I,
  input wire logic [storage_pkg::WADDR_W-1:0] ADDR_I,
  input wire logic [storage_pkg::LANES-1:0] BSEL_I,
  input wire logic [storage_pkg::WORD_W-1:0] WDATA_I,
  input wire logic ABORT_I,
  // cabinet switches
  input wire logic [storage_pkg::N_CAB*storage_pkg::CAB_BITS-1:0] CAB_BASE_I,
  input wire logic [storage_pkg::N_CAB-1:0] CAB_ONLINE_I,
  // answer
  output logic BUSY_O,
  output logic DONE_O,
  output logic [storage_pkg::WORD_W-1:0] RDATA_O,
  output logic [storage_pkg::LANES-1:0] RPAR_O,
  output logic ADDR_ERR_O,
  output logic LOW_AREA_O
);
  import storage_pkg::*;

  mem_port_if mp ();

  word_store i_word_store (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .port(mp.mem)
  );

  // odd parity over one byte
  function automatic logic odd_par(input logic [BYTE_W-1:0] b);
    odd_par = ~(^b);
  endfunction : odd_par

  // find the first online cabinet whose switch base matches the address
  function automatic logic [CAB_BITS:0] cab_find(input logic [WADDR_W-1:0] a,
                                                 input logic [N_CAB*CAB_BITS-1:0] bases,
                                                 input logic [N_CAB-1:0] online);
    logic [CAB_BITS:0] res;
    res = '0;
    if (a[SPACE_MSB:SPACE_LSB] == '0) begin
      for (int c = N_CAB - 1; c >= 0; c--) begin
        if (online[c] && bases[c*CAB_BITS +: CAB_BITS] == a[CAB_MSB:CAB_LSB]) begin
          res = {1'b1, CAB_BITS'(c)};
        end
      end
    end
    cab_find = res;
  endfunction : cab_find

  state_type state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic we_r, we_nxt;
  logic abort_r, abort_nxt;
  logic hit_r, hit_nxt;
  logic [PHYS_AW-1:0] paddr_r, paddr_nxt;
  logic [LANES-1:0] bsel_r, bsel_nxt;
  logic [SWORD_W-1:0] wword_r, wword_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [WORD_W-1:0] rdata_r, rdata_nxt;
  logic [LANES-1:0] rpar_r, rpar_nxt;
  logic err_r, err_nxt;
  logic low_r, low_nxt;
  logic [CAB_BITS:0] found;
  logic take;
  logic last;
  logic commit;
  logic rd_issue;

  // cabinet decode of the incoming word address
  assign found = cab_find(ADDR_I, CAB_BASE_I, CAB_ONLINE_I);
  assign take = (state_r == ST_IDLE) && REQ_I;
  assign last = (state_r == ST_CYCLE) && (cnt_r == CYCLE_CNT - 5'h01);
  // write lands one edge before the end, unless aborted at any point so far
  assign commit = (state_r == ST_CYCLE) && we_r && hit_r && !abort_r && !ABORT_I
                  && (cnt_r == CYCLE_CNT - 5'h02);
  assign rd_issue = (state_r == ST_CYCLE) && !we_r && hit_r && (cnt_r == CNT_RST);

  // storage port drive
  assign mp.en = commit || rd_issue;
  assign mp.we = commit;
  assign mp.addr = paddr_r;
  assign mp.be = bsel_r;
  assign mp.wdata = wword_r;

  // next-state and answer computation
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    we_nxt = we_r;
    abort_nxt = abort_r;
    hit_nxt = hit_r;
    paddr_nxt = paddr_r;
    bsel_nxt = bsel_r;
    wword_nxt = wword_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    rpar_nxt = rpar_r;
    err_nxt = err_r;
    low_nxt = low_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_CYCLE;
          cnt_nxt = CNT_RST;
          we_nxt = WE_I;
          abort_nxt = 1'b0;
          hit_nxt = found[CAB_BITS];
          // word address carries no byte bits, offset within cabinet kept
          paddr_nxt = {found[CAB_BITS-1:0], ADDR_I[CAB_WOFF_W-1:0]};
          bsel_nxt = BSEL_I;
          // lane 3 is the lowest address byte, bits 31:24, bit 0 leftmost
          for (int l = 0; l < LANES; l++) begin
            wword_nxt[l*LANE_W +: LANE_W] = {odd_par(WDATA_I[l*BYTE_W +: BYTE_W]),
                                             WDATA_I[l*BYTE_W +: BYTE_W]};
          end
          busy_nxt = 1'b1;
          err_nxt = !found[CAB_BITS];
          low_nxt = (ADDR_I < LOW_AREA_WORDS);
        end
      end
      ST_CYCLE: begin
        cnt_nxt = cnt_r + 5'h01;
        if (we_r && ABORT_I) begin
          abort_nxt = 1'b1;
        end
        if (last) begin
          state_nxt = ST_IDLE;
          cnt_nxt = CNT_RST;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          // read data come from the array untouched, lanes split to bytes
          for (int l = 0; l < LANES; l++) begin
            rdata_nxt[l*BYTE_W +: BYTE_W] = (!we_r && hit_r) ? mp.rdata[l*LANE_W +: BYTE_W] : 8'h00;
            rpar_nxt[l] = (!we_r && hit_r) ? mp.rdata[l*LANE_W + BYTE_W] : 1'b0;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = CNT_RST;
        busy_nxt = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
      cnt_r <= CNT_RST;
      we_r <= 1'b0;
      abort_r <= 1'b0;
      hit_r <= 1'b0;
      paddr_r <= '0;
      bsel_r <= '0;
      wword_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= RDATA_RST;
      rpar_r <= RPAR_RST;
      err_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      we_r <= we_nxt;
      abort_r <= abort_nxt;
      hit_r <= hit_nxt;
      paddr_r <= paddr_nxt;
      bsel_r <= bsel_nxt;
      wword_r <= wword_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      rpar_r <= rpar_nxt;
      err_r <= err_nxt;
      low_r <= low_nxt;
    end
  end

  // outputs straight from flip-flops
  assign BUSY_O = busy_r;
  assign DONE_O = done_r;
  assign RDATA_O = rdata_r;
  assign RPAR_O = rpar_r;
  assign ADDR_ERR_O = err_r;
  assign LOW_AREA_O = low_r;

endmodule : main_storage_word_port

/* File: logic/storage_pkg.sv */
// storage_pkg: constants and types shared by the main storage word port
// assumes a single 40 MHz clock; all sizes are fixed at the documented values
package storage_pkg;

  // clock and cycle timing
  localparam int CLK_NS = 25;
  localparam int CYCLE_NS = 600;
  localparam logic [4:0] CYCLE_CNT = 5'((CYCLE_NS + CLK_NS - 1) / CLK_NS);

  // address layout: word address is the byte address without its two low bits
  localparam int WADDR_W = 22;
  localparam int BYTE_ADDR_MAX = 1048575;
  localparam int CAB_BYTES = 131072;
  localparam int CAB_BITS = 3;
  localparam int N_CAB = 8;
  localparam int CAB_WOFF_W = 15;
  localparam int PHYS_AW = CAB_BITS + CAB_WOFF_W;
  localparam int CAB_LSB = CAB_WOFF_W;
  localparam int CAB_MSB = CAB_WOFF_W + CAB_BITS - 1;
  localparam int SPACE_MSB = WADDR_W - 1;
  localparam int SPACE_LSB = CAB_MSB + 1;

  // reserved low area, in bytes and in words
  localparam int LOW_AREA_BYTES = 640;
  localparam logic [WADDR_W-1:0] LOW_AREA_WORDS = WADDR_W'(LOW_AREA_BYTES / 4);

  // byte and word shape: eight data bits plus one parity bit
  localparam int BYTE_W = 8;
  localparam int LANES = 4;
  localparam int LANE_W = BYTE_W + 1;
  localparam int WORD_W = BYTE_W * LANES;
  localparam int SWORD_W = LANE_W * LANES;

  // reset values
  localparam logic [WORD_W-1:0] RDATA_RST = 32'h0000_0000;
  localparam logic [LANES-1:0] RPAR_RST = 4'h0;
  localparam logic [4:0] CNT_RST = 5'h00;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CYCLE = 1'b1
  } state_type;

endpackage : storage_pkg

/* File: logic/mem_port_if.sv */
// mem_port_if: carries one word access from the controller to the storage array
// assumes both ends share the system clock
`timescale 1ns/100ps
interface mem_port_if;
  import storage_pkg::*;
  logic en;
  logic we;
  logic [PHYS_AW-1:0] addr;
  logic [LANES-1:0] be;
  logic [SWORD_W-1:0] wdata;
  logic [SWORD_W-1:0] rdata;

  modport ctl (output en, output we, output addr, output be, output wdata, input rdata);
  modport mem (input en, input we, input addr, input be, input wdata, output rdata);
endinterface : mem_port_if

/* File: logic/word_store.sv */
// word_store: array of 36-bit words, nine bits per byte lane, registered read
// assumes the controller never reads and writes in the same cycle
`timescale 1ns/100ps
module word_store (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // access port
  mem_port_if.mem port
);
  import storage_pkg::*;

  logic [SWORD_W-1:0] cells [0:(1 << PHYS_AW)-1];
  logic [SWORD_W-1:0] rdata_r;

  assign port.rdata = rdata_r;

  // per-lane write keeps unselected lanes, read leaves contents intact
  always_ff @(posedge clk_i) begin
    if (port.en && port.we) begin
      for (int l = 0; l < LANES; l++) begin
        if (port.be[l]) begin
          cells[port.addr][l*LANE_W +: LANE_W] <= port.wdata[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // read word register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (port.en && !port.we) begin
      rdata_r <= cells[port.addr];
    end
  end

endmodule : word_store

/* File: verification/storage_port_properties.sv */
// storage_port_properties: cycle timing and answer checks at the port
// assumes a bind onto main_storage_word_port, one clock domain
`timescale 1ns/100ps
module storage_port_properties (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // request
  input wire logic REQ_I,
  input wire logic WE_I,
  input wire logic [storage_pkg::WADDR_W-1:0] ADDR_I,
  // answer
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [3:0] RPAR_O,
  input wire logic ADDR_ERR_O,
  input wire logic LOW_AREA_O
);
  import storage_pkg::*;
  logic [4:0] cnt_r;
  logic we_r;
  wire take = REQ_I && !BUSY_O;
  // busy cycle count and kind of access in flight
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_r <= 5'h00;
      we_r <= 1'b0;
    end else begin
      cnt_r <= BUSY_O ? cnt_r + 5'h01 : 5'h00;
      if (take) we_r <= WE_I;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // assertions
  take_busy_a: assert property (take |=> BUSY_O) else $error("busy not raised");
  busy_hold_a: assert property (BUSY_O && cnt_r < CYCLE_CNT - 5'h01 |=> BUSY_O) else $error("busy short");
  cycle_len_a: assert property (DONE_O |-> cnt_r == CYCLE_CNT) else $error("cycle length");
  done_end_a: assert property ($fell(BUSY_O) |-> DONE_O ##1 !DONE_O) else $error("done pulse");
  write_zero_a: assert property (DONE_O && we_r |-> RDATA_O == 32'h0 && RPAR_O == 4'h0) else $error("write data");
  read_par_a: assert property (DONE_O && !we_r && !ADDR_ERR_O |->
    RPAR_O == {~^RDATA_O[31:24], ~^RDATA_O[23:16], ~^RDATA_O[15:8], ~^RDATA_O[7:0]}) else $error("parity");
  data_hold_a: assert property ($changed(RDATA_O) |-> DONE_O) else $error("data moved");
  high_err_a: assert property (take && ADDR_I[21:18] != 4'h0 |=> ADDR_ERR_O) else $error("no error");
  low_area_a: assert property (take |=> LOW_AREA_O == ($past(ADDR_I) < LOW_AREA_WORDS)) else $error("low");
  // main scenarios
  cover property (take && WE_I);
  cover property (take && !WE_I);
  cover property (DONE_O && ADDR_ERR_O);
endmodule : storage_port_properties
bind main_storage_word_port storage_port_properties i_storage_port_properties (
  .SYS_CLK_I(SYS_CLK_I),
  .RST_I(RST_I),
  .REQ_I(REQ_I),
  .WE_I(WE_I),
  .ADDR_I(ADDR_I),
  .BUSY_O(BUSY_O),
  .DONE_O(DONE_O),
  .RDATA_O(RDATA_O),
  .RPAR_O(RPAR_O),
  .ADDR_ERR_O(ADDR_ERR_O),
  .LOW_AREA_O(LOW_AREA_O)
);

/* File: verification/requester_model.sv */
// requester_model: processor side issuing word storage cycles
// assumes calls start just after a rising edge
`timescale 1ns/100ps
module requester_model (
  // clock and status
  input wire logic clk_i,
  input wire logic busy_i,
  // request lines
  output logic req_o,
  output logic we_o,
  output logic [storage_pkg::WADDR_W-1:0] addr_o,
  output logic [3:0] bsel_o,
  output logic [31:0] wdata_o,
  output logic abort_o
);
  import storage_pkg::*;
  // quiet lines at time zero
  initial begin
    {req_o, we_o, addr_o, bsel_o, wdata_o, abort_o} = '0;
  end
  // hold a request until taken, then drive its abort level
  task automatic req(input logic w, input logic [WADDR_W-1:0] a, input logic [3:0] b,
                     input logic [31:0] d, input logic ab);
    req_o = 1'b1;
    we_o = w;
    addr_o = a;
    bsel_o = w ? b : 4'h0;
    wdata_o = d;
    while (busy_i) @(posedge clk_i) #1;
    @(posedge clk_i) #1;
    abort_o = ab;
  endtask : req
  // release: request dropped, stale write data lines turned over
  task automatic idle();
    req_o = 1'b0;
    wdata_o = ~wdata_o;
  endtask : idle
endmodule : requester_model

/* File: verification/main_storage_word_port_test.sv */
// main_storage_word_port_test: self-checking bench, noted answers in a queue
// assumes a 25 ns clock and one requester model
`timescale 1ns/100ps
module main_storage_word_port_test;
  import storage_pkg::*;
  logic SYS_CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic REQ_I, WE_I, ABORT_I, BUSY_O, DONE_O, ADDR_ERR_O, LOW_AREA_O;
  logic [WADDR_W-1:0] ADDR_I;
  logic [3:0] BSEL_I, RPAR_O;
  logic [31:0] WDATA_I, RDATA_O;
  logic [23:0] CAB_BASE_I = {3'h2, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  logic [7:0] CAB_ONLINE_I = 8'hfb;
  logic [31:0] mem [int];
  logic [WADDR_W-1:0] adr [10];
  logic [37:0] q [$];
  logic [37:0] e;
  int seed = 32'h8d7223e6;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 SYS_CLK_I = ~SYS_CLK_I;
  main_storage_word_port i_main_storage_word_port (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .REQ_I(REQ_I),
    .WE_I(WE_I), .ADDR_I(ADDR_I), .BSEL_I(BSEL_I), .WDATA_I(WDATA_I), .ABORT_I(ABORT_I),
    .CAB_BASE_I(CAB_BASE_I), .CAB_ONLINE_I(CAB_ONLINE_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
    .RDATA_O(RDATA_O), .RPAR_O(RPAR_O), .ADDR_ERR_O(ADDR_ERR_O), .LOW_AREA_O(LOW_AREA_O));
  requester_model i_requester_model (.clk_i(SYS_CLK_I), .busy_i(BUSY_O), .req_o(REQ_I), .we_o(WE_I),
    .addr_o(ADDR_I), .bsel_o(BSEL_I), .wdata_o(WDATA_I), .abort_o(ABORT_I));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // update the model, note the answer, issue the cycle
  task automatic acc(input logic w, input logic [WADDR_W-1:0] a, input logic [3:0] b, input logic ab);
    logic ok;
    logic [31:0] d, r;
    d = $random(seed);
    ok = a[21:18] == 4'h0 && a[17:15] != 3'h7;
    r = (ok && mem.exists(a)) ? mem[a] : 32'h0;
    if (w && ok && !ab) begin
      for (int i = 0; i < 4; i++) if (b[i]) r[8*i+:8] = d[8*i+:8];
      mem[a] = r;
    end
    // note: low area flag, miss flag, parity (zero on write or miss), read data
    q.push_back({a < LOW_AREA_WORDS, !ok, (w || !ok) ? 4'h0 : {~^r[31:24], ~^r[23:16], ~^r[15:8], ~^r[7:0]},
                 w ? 32'h0 : r});
    i_requester_model.req(w, a, b, d, ab);
  endtask : acc
  // compare each finished cycle with the oldest note
  always @(posedge SYS_CLK_I) begin
    #1;
    if (DONE_O === 1'b1) begin
      if (q.size() == 0) check("spare done", 32'h1, 32'h0);
      else begin
        e = q.pop_front();
        check("rdata", RDATA_O, e[31:0]);
        check("rpar", RPAR_O, e[35:32]);
        check("addr_err", ADDR_ERR_O, e[36]);
        check("low_area", LOW_AREA_O, e[37]);
      end
    end
  end
  // hang guard
  always @(posedge SYS_CLK_I) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge SYS_CLK_I);
    #1 RST_I = 1'b0;
    for (int i = 0; i < 10; i++) adr[i] = {4'h0, 3'(i % 7), 15'($random(seed))};
    adr[7] = 22'h0;
    adr[8] = 22'h9f;
    adr[9] = 22'ha0;
    for (int i = 0; i < 10; i++) acc(1'b1, adr[i], 4'hf, 1'b0);
    $display("test full writes done");
    for (int i = 0; i < 16; i++) acc(1'b1, adr[{$random(seed)} % 10], 4'($random(seed)), ($random(seed) & 3) == 0);
    $display("test partial and abort done");
    for (int i = 0; i < 20; i++) acc(1'b0, adr[i / 2], 4'h0, 1'b1);
    $display("test read twice done");
    acc(1'b1, 22'h010012, 4'hf, 1'b0);
    acc(1'b0, 22'h010012, 4'h0, 1'b0);
    acc(1'b1, 22'h038012, 4'hf, 1'b0);
    acc(1'b0, 22'h038012, 4'h0, 1'b0);
    acc(1'b1, 22'h200000, 4'hf, 1'b0);
    acc(1'b0, 22'h200000, 4'h0, 1'b0);
    i_requester_model.idle();
    for (int k = 0; k < 60 && q.size() > 0; k++) @(posedge SYS_CLK_I);
    check("pending", q.size(), 32'h0);
    $display("test unmapped done");
    summarize();
  end
endmodule : main_storage_word_port_test
